// *** sxe_regs.vh ***
`ifndef SXE_REGS_VH
`define SXE_REGS_VH

// AXI4-Lite register byte offsets
`define SXE_OFF_INSTR      8'h00
`define SXE_OFF_ACCUM      8'h04
`define SXE_OFF_STATUS     8'h08
`define SXE_OFF_BANKSEL    8'h0c
`define SXE_OFF_CTRL       8'h10
`define SXE_OFF_ADDR       8'h14
`define SXE_OFF_FILEDATA   8'h18

// Opcode fields of the 16-bit instruction word
`define SXE_OP_SUB_FILE      6'h17
`define SXE_OP_SUB_FILE_BRW  6'h16
`define SXE_OP_SUB_ACCUM_BRW 6'h15
`define SXE_OP_SUB_LIT       8'h08
`define SXE_BIT_D          9
`define SXE_BIT_A          8

// Status bit positions
`define SXE_ST_C           0
`define SXE_ST_DC          1
`define SXE_ST_Z           2
`define SXE_ST_OV          3
`define SXE_ST_N           4

// Control register bit positions
`define SXE_CTRL_EXT       0

// Indexed literal offset limit and access bank split
`define SXE_ILO_LIMIT      8'h5f
`define SXE_ACCESS_SPLIT   8'h60
`define SXE_ACCESS_HI_BANK 4'hf

// Reset values
`define SXE_RST_ACCUM      8'h00
`define SXE_RST_STATUS     5'h00
`define SXE_RST_BANKSEL    4'h0
`define SXE_RST_CTRL       1'b0

`endif

// *** sxe_alu.v ***
`timescale 1ns/10ps
`include "sxe_regs.vh"

// Subtractor: a - b - borrow, with status flags
module sxe_alu (
  // Operands
  input  wire [7:0] op_a,
  input  wire [7:0] op_b,
  input  wire       borrow_in,
  // Results
  output wire [7:0] diff,
  output wire       carry,
  output wire       dcarry,
  output wire       zero,
  output wire       ovf,
  output wire       neg
);
  wire [8:0] full;
  wire [4:0] low;

  // Two's complement: a + ~b + ~borrow; carry set means no borrow
  assign full   = {1'b0, op_a} + {1'b0, ~op_b} + {8'h00, ~borrow_in};
  assign low    = {1'b0, op_a[3:0]} + {1'b0, ~op_b[3:0]} + {4'h0, ~borrow_in};
  assign diff   = full[7:0];
  assign carry  = full[8];
  assign dcarry = low[4];
  assign zero   = (full[7:0] == 8'h00);
  assign ovf    = (op_a[7] != op_b[7]) && (full[7] != op_a[7]);
  assign neg    = full[7];
endmodule // sxe_alu

// *** sxe_core.v ***
// The register offsets and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/10ps
`include "sxe_regs.vh"

module sxe_core (
  // Clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // AXI4-Lite write address
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read address
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // File register port
  output reg  [11:0] file_addr,
  output reg         file_ilo,
  output reg  [7:0]  file_wdata,
  output reg         file_we,
  input  wire [7:0]  file_rdata
);
  reg  [7:0]  accum_r;
  reg  [4:0]  status_r;
  reg  [3:0]  banksel_r;
  reg         ctrl_ext_r;
  reg  [15:0] instr_r;
  reg  [7:0]  fdata_r;
  reg         aw_got_r;
  reg         w_got_r;
  reg  [7:0]  aw_addr_r;
  reg  [31:0] w_data_r;
  reg  [3:0]  w_strb_r;
  reg         exec_r;

  wire       wr_go;
  wire       is_wf;
  wire       is_wfb;
  wire       is_fwb;
  wire       is_lw;
  wire       legal;
  wire       d_bit;
  wire       a_bit;
  wire [7:0] fadr;
  reg  [7:0] op_a;
  reg  [7:0] op_b;
  reg        bin;
  wire [7:0] diff;
  wire       c_o;
  wire       dc_o;
  wire       z_o;
  wire       ov_o;
  wire       n_o;

  // Write channels held until both seen; response slot must be free
  assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_got_r && !s_axi_bvalid;
  assign wr_go         = aw_got_r && w_got_r && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  // Instruction decode
  assign is_wf  = (instr_r[15:10] == `SXE_OP_SUB_FILE);
  assign is_wfb = (instr_r[15:10] == `SXE_OP_SUB_FILE_BRW);
  assign is_fwb = (instr_r[15:10] == `SXE_OP_SUB_ACCUM_BRW);
  assign is_lw  = (instr_r[15:8] == `SXE_OP_SUB_LIT);
  assign legal  = is_wf || is_wfb || is_fwb || is_lw;
  assign d_bit  = instr_r[`SXE_BIT_D];
  assign a_bit  = instr_r[`SXE_BIT_A];
  assign fadr   = instr_r[7:0];

  // Operand select; file data taken live so the new address is used
  always @* begin
    op_a = file_rdata;
    op_b = accum_r;
    bin  = 1'b0;
    if (is_lw) begin
      op_a = instr_r[7:0];
    end else if (is_fwb) begin
      op_a = accum_r;
      op_b = file_rdata;
      bin  = ~status_r[`SXE_ST_C];
    end else if (is_wfb) begin
      bin  = ~status_r[`SXE_ST_C];
    end
  end

  sxe_alu u_alu (
    .op_a      (op_a),
    .op_b      (op_b),
    .borrow_in (bin),
    .diff      (diff),
    .carry     (c_o),
    .dcarry    (dc_o),
    .zero      (z_o),
    .ovf       (ov_o),
    .neg       (n_o)
  );

  // Operand address: access bank, selected bank, or indexed offset
  always @* begin
    file_ilo = 1'b0;
    if (!a_bit) begin
      if (fadr < `SXE_ACCESS_SPLIT)
        file_addr = {4'h0, fadr};
      else
        file_addr = {`SXE_ACCESS_HI_BANK, fadr};
      file_ilo = ctrl_ext_r && (fadr <= `SXE_ILO_LIMIT);
    end else begin
      file_addr = {banksel_r, fadr};
    end
  end

  // Register bus, execution and write-back
  always @(posedge aclk) begin
    if (!aresetn) begin
      accum_r      <= `SXE_RST_ACCUM;
      status_r     <= `SXE_RST_STATUS;
      banksel_r    <= `SXE_RST_BANKSEL;
      ctrl_ext_r   <= `SXE_RST_CTRL;
      instr_r      <= 16'h0000;
      fdata_r      <= 8'h00;
      aw_got_r     <= 1'b0;
      w_got_r      <= 1'b0;
      aw_addr_r    <= 8'h00;
      w_data_r     <= 32'h00000000;
      w_strb_r     <= 4'h0;
      exec_r       <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= 2'b00;
      s_axi_rdata  <= 32'h00000000;
      file_we      <= 1'b0;
      file_wdata   <= 8'h00;
    end else begin
      file_we <= 1'b0;
      exec_r  <= 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r  <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r  <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      // Registers take only the low byte lane or two
      if (wr_go) begin
        aw_got_r     <= 1'b0;
        w_got_r      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= 2'b00;
        case (aw_addr_r)
          `SXE_OFF_INSTR: begin
            if (w_strb_r[0]) instr_r[7:0]  <= w_data_r[7:0];
            if (w_strb_r[1]) instr_r[15:8] <= w_data_r[15:8];
            exec_r <= 1'b1;                          // Writing starts one execution
          end
          `SXE_OFF_ACCUM:    if (w_strb_r[0]) accum_r <= w_data_r[7:0];
          `SXE_OFF_STATUS:   if (w_strb_r[0]) status_r <= w_data_r[4:0];
          `SXE_OFF_BANKSEL:  if (w_strb_r[0]) banksel_r <= w_data_r[3:0];
          `SXE_OFF_CTRL:     if (w_strb_r[0]) ctrl_ext_r <= w_data_r[`SXE_CTRL_EXT];
          default:           s_axi_bresp <= 2'b10;
        endcase
      end
      // Execute: file operand read combinationally at the decoded address
      if (exec_r && legal) begin
        status_r[`SXE_ST_C]  <= c_o;
        status_r[`SXE_ST_DC] <= dc_o;
        status_r[`SXE_ST_Z]  <= z_o;
        status_r[`SXE_ST_OV] <= ov_o;
        status_r[`SXE_ST_N]  <= n_o;
        if (is_lw || !d_bit) begin
          accum_r <= diff;
        end else begin
          file_we    <= 1'b1;
          file_wdata <= diff;
        end
      end
      // Snapshot of the file port for software readback only
      fdata_r <= file_rdata;
      if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'b00;
        case (s_axi_araddr)
          `SXE_OFF_INSTR:    s_axi_rdata <= {16'h0000, instr_r};
          `SXE_OFF_ACCUM:    s_axi_rdata <= {24'h000000, accum_r};
          `SXE_OFF_STATUS:   s_axi_rdata <= {27'h0000000, status_r};
          `SXE_OFF_BANKSEL:  s_axi_rdata <= {28'h0000000, banksel_r};
          `SXE_OFF_CTRL:     s_axi_rdata <= {31'h00000000, ctrl_ext_r};
          `SXE_OFF_ADDR:     s_axi_rdata <= {19'h00000, file_ilo, file_addr};
          `SXE_OFF_FILEDATA: s_axi_rdata <= {24'h000000, fdata_r};
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'b10;
          end
        endcase
      end
    end
  end
endmodule // sxe_core

// *** sxe_core_asserts.sv ***
`timescale 1ns/10ps
module sxe_core_asserts (
  // Clock and reset
  input wire        aclk,
  input wire        aresetn,
  // Bus handshakes
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  // File port
  input wire [11:0] file_addr,
  input wire        file_we
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_we_one_pulse: assert property (file_we |=> !file_we)
    else $error("file write strobe too long");
  a_we_after_resp: assert property (file_we |-> s_axi_bvalid || $past(s_axi_bvalid))
    else $error("file write without instruction");
  a_we_addr_held: assert property (file_we |-> $stable(file_addr))
    else $error("file address moved during write");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_b_resp_code: assert property (s_axi_bvalid |-> !s_axi_bresp[0])
    else $error("bad write response code");
  a_b_after_aw: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_r_after_ar: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read data dropped");
  // Main scenarios seen
  cover property (file_we);
  cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
  cover property (s_axi_rvalid && s_axi_rready);
endmodule // sxe_core_asserts

bind sxe_core sxe_core_asserts i_sxe_core_asserts (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .file_addr(file_addr), .file_we(file_we));

// *** sxe_core_bench.sv ***
`timescale 1ns/10ps
`include "sxe_regs.vh"
module sxe_core_bench;
  reg         aclk, aresetn, awv, wv, bry, arv, rry;
  reg  [7:0]  awa, ara, f, w, wdv;
  reg  [31:0] wd, rv;
  reg  [1:0]  rs, op;
  reg  [4:0]  st;
  reg  [3:0]  bk;
  reg  [11:0] ea, wa;
  reg  [12:0] e;
  reg         d, ab, ext, ilo, wrote;
  wire        awr, wrd, bv, arr, rvl, file_we, file_ilo;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  wire [11:0] file_addr;
  wire [7:0]  file_wdata, file_rdata;
  integer     i, n0, nwe, n_mismatch, n_checks;

  sxe_core i_sxe_core (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrd),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bry),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvl), .s_axi_rready(rry),
    .file_addr(file_addr), .file_ilo(file_ilo), .file_wdata(file_wdata),
    .file_we(file_we), .file_rdata(file_rdata));

  // File memory stand-in: content depends on every address bit
  assign file_rdata = file_addr[7:0] ^ {file_addr[11:8], 4'h9};

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  // Record file writes; a count catches doubled or missing strobes
  always @(posedge aclk) if (file_we) begin
    nwe <= nwe + 1;
    wa <= file_addr;
    wdv <= file_wdata;
  end

  task chk(input [31:0] ev, input [31:0] sv, input string nm);
    begin
      n_checks = n_checks + 1;
      if (sv !== ev) begin
        n_mismatch = n_mismatch + 1;
        $display("wrong value %s expected %h seen %h", nm, ev, sv);
      end
    end
  endtask

  // Address and data offered together, each released once taken
  task wr(input [7:0] a, input [31:0] dv);
    begin
      awa <= a;
      wd <= dv;
      awv <= 1'b1;
      wv <= 1'b1;
      bry <= 1'b1;
      do begin
        @(posedge aclk);
        if (awr) awv <= 1'b0;
        if (wrd) wv <= 1'b0;
      end while (bv !== 1'b1);
      rs = bresp;
      bry <= 1'b0;
      @(posedge aclk);
    end
  endtask

  task rd(input [7:0] a);
    begin
      ara <= a;
      arv <= 1'b1;
      rry <= 1'b1;
      do begin
        @(posedge aclk);
        if (arr) arv <= 1'b0;
      end while (rvl !== 1'b1);
      rv = rdata;
      rs = rresp;
      rry <= 1'b0;
      @(posedge aclk);
    end
  endtask

  // {N, OV, Z, DC, C, result} of a - b - borrow
  function [12:0] ex(input [7:0] a, input [7:0] b, input bi);
    reg [8:0] r;
    reg [4:0] l;
    begin
      r = {1'b0, a} - b - bi;
      l = {1'b0, a[3:0]} - b[3:0] - bi;
      ex = {r[7], (a[7] ^ b[7]) & (r[7] ^ a[7]), r[7:0] == 8'h00, ~l[4], ~r[8], r[7:0]};
    end
  endfunction

  task complete_run;
    begin
      if (n_mismatch == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask

  // Watchdog, far beyond the expected run of about 1500 cycles
  initial begin
    #500000;
    n_mismatch = n_mismatch + 1;
    complete_run;
  end

  initial begin
    {aresetn, awv, wv, bry, arv, rry, awa, ara, wd} = 0;
    {n_mismatch, n_checks, nwe} = 0;
    i = $urandom(32'h4dc0);
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    // First eight runs sit on the access bank and offset-mode borders
    for (i = 0; i < 48; i = i + 1) begin
      op = i % 4;
      {f, w, st, bk, d, ab, ext} = {$urandom, $urandom};
      if (i < 8) {f, ab, ext} = {i[2] ? 8'h5f : 8'h60, 2'b01};
      wr(`SXE_OFF_ACCUM, w);
      wr(`SXE_OFF_STATUS, st);
      wr(`SXE_OFF_BANKSEL, bk);
      wr(`SXE_OFF_CTRL, ext);
      ea = ab ? {bk, f} : {f < `SXE_ACCESS_SPLIT ? 4'h0 : `SXE_ACCESS_HI_BANK, f};
      ilo = op != 3 && !ab && ext && f <= 8'h5f;
      e = op == 0 ? ex(file_rdata_of(ea), w, 1'b0) : op == 1 ? ex(file_rdata_of(ea), w, ~st[0]) :
          op == 2 ? ex(w, file_rdata_of(ea), ~st[0]) : ex(f, w, 1'b0);
      wrote = op != 3 && d && !ilo;
      n0 = nwe;
      wr(`SXE_OFF_INSTR, op == 3 ? {`SXE_OP_SUB_LIT, f} :
        {op == 0 ? `SXE_OP_SUB_FILE : op == 1 ? `SXE_OP_SUB_FILE_BRW : `SXE_OP_SUB_ACCUM_BRW, d, ab, f});
      chk(2'b00, rs, "instruction write response");
      if (op != 3) rd(`SXE_OFF_ADDR);
      if (op != 3) chk(ilo, rv[12], "offset mode");
      if (!ilo) begin
        if (op != 3) chk(ea, rv[11:0], "file address");
        rd(`SXE_OFF_ACCUM);
        chk(wrote ? w : e[7:0], rv[7:0], "accumulator");
        rd(`SXE_OFF_STATUS);
        chk(e[12:8], rv[4:0], "status");
        chk(wrote, nwe - n0, "file writes");
        if (wrote) chk({ea, e[7:0]}, {wa, wdv}, "file write");
        if (op != 3) rd(`SXE_OFF_FILEDATA);
        if (op != 3) chk(file_rdata_of(ea), rv[7:0], "file data");
      end
    end
    // Undecoded opcode must leave accumulator and file alone
    wr(`SXE_OFF_ACCUM, 32'h5a);
    n0 = nwe;
    wr(`SXE_OFF_INSTR, 32'h0);
    rd(`SXE_OFF_ACCUM);
    chk(8'h5a, rv[7:0], "accumulator after undecoded opcode");
    chk(0, nwe - n0, "file writes after undecoded opcode");
    // Mid-run reset returns the registers to their reset values
    wr(`SXE_OFF_CTRL, 32'h1);
    wr(`SXE_OFF_BANKSEL, 32'h7);
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`SXE_OFF_ACCUM);
    chk(`SXE_RST_ACCUM, rv[7:0], "accumulator after reset");
    rd(`SXE_OFF_STATUS);
    chk(`SXE_RST_STATUS, rv[4:0], "status after reset");
    rd(`SXE_OFF_BANKSEL);
    chk(`SXE_RST_BANKSEL, rv[3:0], "bank select after reset");
    rd(`SXE_OFF_CTRL);
    chk(`SXE_RST_CTRL, rv[0], "extended set after reset");
    wr(`SXE_OFF_ADDR, 32'h0);
    chk(2'b10, rs, "read-only write");
    rd(8'h1c);
    chk(2'b10, rs, "unmapped read");
    complete_run;
  end

  function [7:0] file_rdata_of(input [11:0] a);
    file_rdata_of = a[7:0] ^ {a[11:8], 4'h9};
  endfunction
endmodule // sxe_core_bench
